// ---- inc/gst_pkg.sv ----
// Contract
// - byte reads stay valid during asynchronous counting
// - gate source: gate pin or comparator two
// - run off stops; gate enable gates counting
// - polarity bit chooses active-high or active-low gate
// - rollover FFFF to 0000 sets overflow flag
// - request needs overflow, peripheral, global enables
// - sleep counting only in asynchronous external mode
// - overflow in sleep wakes when enabled
// - falling edge needed before first rising increment
// - prescale field divides by 1, 2, 4, 8
// - oscillator enable honoured only internal-oscillator mode
// - sync bypass bit selects unsynchronised external clock
// - clock source: external rising edges or fosc/4
// - run bit starts and stops counter
// - counter byte write clears prescale counter
package gst_pkg;
	// register byte offsets on the plain register port
	localparam logic [3:0] ADDR_CONTROL  = 4'h0;
	localparam logic [3:0] ADDR_COUNT_LO = 4'h1;
	localparam logic [3:0] ADDR_COUNT_HI = 4'h2;
	localparam logic [3:0] ADDR_GATE_SRC = 4'h3;
	localparam logic [3:0] ADDR_FLAGS    = 4'h4;
	localparam logic [3:0] ADDR_ENABLES  = 4'h5;
	localparam logic [3:0] ADDR_INTCTL   = 4'h6;
	// control register fields
	localparam int CTL_RUN      = 0;
	localparam int CTL_CLK_SRC  = 1;
	localparam int CTL_SYNC_BYP = 2;
	localparam int CTL_LP_OSC   = 3;
	localparam int CTL_PSC_LO   = 4;
	localparam int CTL_GATE_EN  = 6;
	localparam int CTL_GATE_POL = 7;
	// gate source register fields
	localparam int GSS_CMP_SYNC = 0;
	localparam int GSS_SOURCE   = 1;
	// flag, enable and interrupt control fields
	localparam int FLG_OVERFLOW = 0;
	localparam int ENA_OVERFLOW = 0;
	localparam int ICT_PERIPH   = 6;
	localparam int ICT_GLOBAL   = 7;
	// reset values
	localparam logic [7:0] RST_CONTROL  = 8'h00;
	localparam logic [7:0] RST_GATE_SRC = 8'h02;
	localparam logic [7:0] RST_ZERO     = 8'h00;
	// internal clock is oscillator divided by four
	localparam logic [1:0] INT_PHASE_LAST = 2'h3;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage

// ---- rtl/gst_timer.sv ----
`timescale 1ns/10ps
module gst_timer #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic          wr_en,
	input  wire logic          rd_en,
	output logic [DW-1:0]      rdata,
	input  wire logic          external_clock_pin,
	input  wire logic          gate_pin,
	input  wire logic          comparator_two_output,
	input  wire logic          internal_oscillator,
	input  wire logic          sleep_mode,
	output logic               lp_osc_enable,
	output logic               irq_req,
	output logic               wake_req
);
	// reset release chain
	logic            rst_m_r;
	logic            rst_s_r;
	// software registers
	logic [7:0]      ctl_r;           // timer_control
	logic [7:0]      gss_r;           // gate_source_select
	logic [15:0]     count_r;         // count_high_byte:count_low_byte
	logic            ovf_flag_r;      // overflow_flag
	logic            ovf_ie_r;        // overflow_irq_enable
	logic            periph_ie_r;     // peripheral_irq_enable
	logic            global_ie_r;     // global_irq_enable
	// clocking internals
	logic [1:0]      phase_r;         // fosc/4 divider
	logic [2:0]      pre_cnt_r;       // prescale counter
	logic            ext_s1_r;        // synchroniser stage one
	logic            ext_s2_r;        // synchroniser stage two
	logic            ext_prev_r;      // last sample of chosen clock
	logic            armed_r;         // falling edge seen
	// output registers
	logic [DW-1:0]   rdata_r;
	logic            irq_req_r;
	logic            wake_req_r;
	logic            lp_osc_r;
	// decoded control fields
	logic            run_bit;
	logic            clock_source_bit;
	logic            sync_bypass_bit;
	logic            gate_enable_bit;
	logic            gate_polarity_bit;
	logic [1:0]      prescale_field;
	logic            gate_source_bit;
	// datapath nets
	logic            ext_sel;
	logic            ext_rise;
	logic            ext_fall;
	logic            int_tick;
	logic            src_tick;
	logic            gate_raw;
	logic            gate_active;
	logic            count_en;
	logic            pre_tick;
	logic [2:0]      div_m1;
	logic            inc;
	logic            wr_lo;
	logic            wr_hi;
	logic            wr_cnt;
	logic            rst_int_n;

	// two flops release the reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_r <= 1'b0;
			rst_s_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_s_r <= rst_m_r;
		end
	end
	assign rst_int_n = rst_s_r;

	// field decode
	assign run_bit           = ctl_r[gst_pkg::CTL_RUN];
	assign clock_source_bit  = ctl_r[gst_pkg::CTL_CLK_SRC];
	assign sync_bypass_bit   = ctl_r[gst_pkg::CTL_SYNC_BYP];
	assign gate_enable_bit   = ctl_r[gst_pkg::CTL_GATE_EN];
	assign gate_polarity_bit = ctl_r[gst_pkg::CTL_GATE_POL];
	assign prescale_field    = ctl_r[gst_pkg::CTL_PSC_LO +: 2];
	assign gate_source_bit   = gss_r[gst_pkg::GSS_SOURCE];

	// byte write strobes for the counter
	assign wr_lo  = wr_en && (addr == gst_pkg::ADDR_COUNT_LO);
	assign wr_hi  = wr_en && (addr == gst_pkg::ADDR_COUNT_HI);
	assign wr_cnt = wr_lo || wr_hi;

	// fosc/4 phase counter, free running
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			phase_r <= 2'h0;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end
	assign int_tick = (phase_r == gst_pkg::INT_PHASE_LAST);

	// external clock synchroniser, stage one read only by stage two
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
		end else begin
			ext_s1_r <= external_clock_pin;
			ext_s2_r <= ext_s1_r;
		end
	end

	// pick raw pin or synchronised copy
	assign ext_sel = sync_bypass_bit ? external_clock_pin : ext_s2_r;

	// edge detector on the chosen clock
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			ext_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= ext_sel;
		end
	end
	assign ext_rise = ext_sel && !ext_prev_r;
	assign ext_fall = !ext_sel && ext_prev_r;

	// arm on a falling edge before any rising edge counts
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			armed_r <= 1'b0;
		end else if (!run_bit || !clock_source_bit) begin
			armed_r <= 1'b0;
		end else if (ext_fall) begin
			armed_r <= 1'b1;
		end
	end

	// clock source selection
	assign src_tick = clock_source_bit ? (ext_rise && armed_r) : int_tick;

	// gate source and polarity
	assign gate_raw    = gate_source_bit ? gate_pin : comparator_two_output;
	assign gate_active = gate_polarity_bit ? gate_raw : !gate_raw;

	// run, gate and sleep qualify counting
	assign count_en = run_bit
		&& (!gate_enable_bit || gate_active)
		&& (!sleep_mode || (clock_source_bit && sync_bypass_bit));
	assign pre_tick = src_tick && count_en;

	// prescale terminal count
	always_comb begin
		case (prescale_field)
			2'h0:    div_m1 = 3'h0;
			2'h1:    div_m1 = 3'h1;
			2'h2:    div_m1 = 3'h3;
			2'h3:    div_m1 = 3'h7;
			default: div_m1 = 3'h0;
		endcase
	end
	assign inc = pre_tick && (pre_cnt_r >= div_m1);

	// prescale counter, cleared by counter writes
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			pre_cnt_r <= 3'h0;
		end else if (wr_cnt) begin
			pre_cnt_r <= 3'h0;
		end else if (pre_tick) begin
			if (pre_cnt_r >= div_m1) begin
				pre_cnt_r <= 3'h0;
			end else begin
				pre_cnt_r <= pre_cnt_r + 3'h1;
			end
		end
	end

	// counter pair, byte writes take priority over increment
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			count_r <= {gst_pkg::RST_ZERO, gst_pkg::RST_ZERO};
		end else if (wr_lo) begin
			count_r[7:0] <= wdata[7:0];
		end else if (wr_hi) begin
			count_r[15:8] <= wdata[7:0];
		end else if (inc) begin
			count_r <= count_r + 16'h0001;
		end
	end

	// control and gate source registers
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			ctl_r <= gst_pkg::RST_CONTROL;
			gss_r <= gst_pkg::RST_GATE_SRC;
		end else if (wr_en) begin
			if (addr == gst_pkg::ADDR_CONTROL) begin
				ctl_r <= wdata[7:0];
			end
			if (addr == gst_pkg::ADDR_GATE_SRC) begin
				gss_r <= {6'h00, wdata[1:0]};
			end
		end
	end

	// overflow flag, hardware set beats software clear
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			ovf_flag_r <= 1'b0;
		end else if (inc && (count_r == gst_pkg::COUNT_MAX) && !wr_cnt) begin
			ovf_flag_r <= 1'b1;
		end else if (wr_en && (addr == gst_pkg::ADDR_FLAGS)) begin
			ovf_flag_r <= wdata[gst_pkg::FLG_OVERFLOW];
		end
	end

	// interrupt enable bits
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			ovf_ie_r    <= 1'b0;
			periph_ie_r <= 1'b0;
			global_ie_r <= 1'b0;
		end else if (wr_en) begin
			if (addr == gst_pkg::ADDR_ENABLES) begin
				ovf_ie_r <= wdata[gst_pkg::ENA_OVERFLOW];
			end
			if (addr == gst_pkg::ADDR_INTCTL) begin
				periph_ie_r <= wdata[gst_pkg::ICT_PERIPH];
				global_ie_r <= wdata[gst_pkg::ICT_GLOBAL];
			end
		end
	end

	// request, wake and oscillator outputs
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			irq_req_r  <= 1'b0;
			wake_req_r <= 1'b0;
			lp_osc_r   <= 1'b0;
		end else begin
			irq_req_r  <= ovf_flag_r && ovf_ie_r && periph_ie_r && global_ie_r;
			wake_req_r <= sleep_mode && run_bit && ovf_flag_r && ovf_ie_r
				&& periph_ie_r;
			lp_osc_r   <= internal_oscillator && ctl_r[gst_pkg::CTL_LP_OSC];
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			rdata_r <= '0;
		end else if (rd_en) begin
			case (addr)
				gst_pkg::ADDR_CONTROL:  rdata_r <= ctl_r;
				gst_pkg::ADDR_COUNT_LO: rdata_r <= count_r[7:0];
				gst_pkg::ADDR_COUNT_HI: rdata_r <= count_r[15:8];
				gst_pkg::ADDR_GATE_SRC: rdata_r <= gss_r;
				gst_pkg::ADDR_FLAGS:    rdata_r <= {7'h00, ovf_flag_r};
				gst_pkg::ADDR_ENABLES:  rdata_r <= {7'h00, ovf_ie_r};
				gst_pkg::ADDR_INTCTL:   rdata_r <= {global_ie_r, periph_ie_r, 6'h00};
				default:                rdata_r <= '0;
			endcase
		end else begin
			rdata_r <= '0;
		end
	end

	assign rdata         = rdata_r;
	assign irq_req       = irq_req_r;
	assign wake_req      = wake_req_r;
	assign lp_osc_enable = lp_osc_r;

	// checks on the counting path
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_int_n);

	a_stop_holds_count: assert property (
		!run_bit && !wr_cnt |=> count_r == $past(count_r))
		else $error("counter moved while stopped");

	a_gate_blocks_count: assert property (
		run_bit && gate_enable_bit && !gate_active && !wr_cnt |=> $stable(count_r))
		else $error("counter moved with gate inactive");

	// an inactive pin gate must block every prescaler tick
	a_gate_mux_sense: assert property (
		run_bit && gate_enable_bit && gate_source_bit && (gate_polarity_bit != gate_pin) |-> !pre_tick)
		else $error("gate sense wrong");

	// an inactive comparator two gate, when it is the chosen source, must block every prescaler tick
	a_cmp_gate_path: assert property (
		run_bit && gate_enable_bit && !gate_source_bit && (gate_polarity_bit != comparator_two_output)
		|-> !pre_tick)
		else $error("comparator gate ignored");

	a_rollover_flag: assert property (
		inc && count_r == gst_pkg::COUNT_MAX && !wr_cnt |=> ovf_flag_r && count_r == 16'h0000)
		else $error("rollover did not set flag");

	a_irq_all_enables: assert property (
		irq_req_r == $past(ovf_flag_r && ovf_ie_r && periph_ie_r && global_ie_r))
		else $error("request without all enables");

	a_sleep_freezes: assert property (
		sleep_mode && !(clock_source_bit && sync_bypass_bit) && !wr_cnt |=> $stable(count_r))
		else $error("counter moved in sleep");

	a_wake_cause: assert property (
		wake_req_r |-> $past(sleep_mode && run_bit && ovf_flag_r && ovf_ie_r))
		else $error("wake without cause");

	a_arm_before_rise: assert property (
		clock_source_bit && pre_tick |-> armed_r)
		else $error("count before falling edge");

	a_write_clears_pre: assert property (
		wr_cnt |=> pre_cnt_r == 3'h0)
		else $error("prescaler not cleared");

	a_sync_two_stage: assert property (
		clock_source_bit && !sync_bypass_bit && ext_rise && $stable(ctl_r)
		|-> $past(external_clock_pin, 2) && !$past(external_clock_pin, 3))
		else $error("sync path not two stages");

	a_lp_osc_gate: assert property (
		lp_osc_r |-> $past(internal_oscillator))
		else $error("oscillator enabled outside mode");

	// nothing but a software write may lower the flag
	a_flag_holds: assert property (
		ovf_flag_r && !(wr_en && addr == gst_pkg::ADDR_FLAGS) |=> ovf_flag_r)
		else $error("overflow flag cleared by hardware");

	// read data stands one cycle, then returns to zero
	a_rdata_idle: assert property (
		!$past(rd_en) |-> rdata_r == '0)
		else $error("read data not idle");

	// free-running timer at 1:1 steps once per internal tick
	a_run_counts: assert property (
		run_bit && !gate_enable_bit && !clock_source_bit && !sleep_mode && !wr_cnt
		&& prescale_field == 2'h0 && int_tick |=> count_r == $past(count_r) + 16'h0001)
		else $error("timer missed an internal tick");

	c_rollover:  cover property (inc && count_r == gst_pkg::COUNT_MAX);
	c_wake:      cover property (wake_req_r);
	c_gated_inc: cover property (gate_enable_bit && inc);
	c_div8_inc:  cover property (prescale_field == 2'h3 && inc);
	c_sleep_inc: cover property (sleep_mode && inc);
endmodule

// ---- bench/gst_partner.sv ----
`timescale 1ns/10ps
module gst_partner #(
	parameter int HALF = 5
) (
	input  wire logic clock,
	input  wire logic ext_run,
	input  wire logic gate_lvl,
	input  wire logic cmp_lvl,
	output logic      external_clock_pin,
	output logic      gate_pin,
	output logic      comparator_two_output
);
	int   cnt_r = 0;    // half period counter
	logic pin_r = 1'b0; // external clock level
	// external clock runs only on request, stands low between runs
	always @(posedge clock) begin
		if (!ext_run) begin
			cnt_r <= 0;
			pin_r <= 1'b0;
		end else if (cnt_r == HALF - 1) begin
			cnt_r <= 0;
			pin_r <= ~pin_r;
		end else begin
			cnt_r <= cnt_r + 1;
		end
	end
	assign external_clock_pin = pin_r;
	// both gate sources driven independently
	assign gate_pin = gate_lvl;
	assign comparator_two_output = cmp_lvl;
endmodule

// ---- bench/gst_timer_tb_top.sv ----
`timescale 1ns/10ps
module gst_timer_tb_top;
	logic        clock      = 1'b0;
	logic        rst_n      = 1'b0;
	logic [3:0]  addr       = 4'h0;
	logic [7:0]  wdata      = 8'h00;
	logic        wr_en      = 1'b0;
	logic        rd_en      = 1'b0;
	logic        ext_run    = 1'b0;
	logic        gate_lvl   = 1'b0;
	logic        cmp_lvl    = 1'b0;
	logic        int_osc    = 1'b0;
	logic        sleep_mode = 1'b0;
	logic        rd_pend    = 1'b0;
	logic [7:0]  rdata;
	logic        ext_clk;
	logic        gate_p;
	logic        cmp_o;
	logic        lp_osc;
	logic        irq_req;
	logic        wake_req;
	logic [15:0] v;
	logic [7:0]  lo_q[$];
	logic [7:0]  hi_q[$];
	int          err_total  = 0;
	int          compares   = 0;
	int          seed       = 32'hc885;

	gst_timer DUT (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .external_clock_pin(ext_clk), .gate_pin(gate_p),
		.comparator_two_output(cmp_o), .internal_oscillator(int_osc), .sleep_mode(sleep_mode),
		.lp_osc_enable(lp_osc), .irq_req(irq_req), .wake_req(wake_req));
	gst_partner PRT (.clock(clock), .ext_run(ext_run), .gate_lvl(gate_lvl), .cmp_lvl(cmp_lvl),
		.external_clock_pin(ext_clk), .gate_pin(gate_p), .comparator_two_output(cmp_o));

	initial begin
		forever #5 clock = ~clock;
	end

	task automatic fail(input string m);
		err_total++;
		$display("MISMATCH t=%0t %s", $time, m);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
		@(posedge clock);
	endtask
	// expected byte range noted before the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi);
		lo_q.push_back(lo);
		hi_q.push_back(hi);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		@(posedge clock);
	endtask
	// level outputs looked at on the edge, settled from the cycle before
	task automatic chk_bit(input logic got, input logic exp, input string m);
		compares++;
		if (got !== exp) fail(m);
	endtask
	// oldest noted byte range against the read data
	task automatic chk_rd(input logic [7:0] got);
		compares++;
		if (!((got >= lo_q[0]) === 1'b1 && (got <= hi_q[0]) === 1'b1)) fail("read data");
		void'(lo_q.pop_front());
		void'(hi_q.pop_front());
	endtask
	// run for n+2 cycles from a cleared counter, then read low byte
	task automatic meas(input logic [7:0] ctl, input int n, input logic [7:0] lo, input logic [7:0] hi);
		wr(gst_pkg::ADDR_CONTROL, 8'h00);
		wr(gst_pkg::ADDR_COUNT_LO, 8'h00);
		wr(gst_pkg::ADDR_COUNT_HI, 8'h00);
		wr(gst_pkg::ADDR_CONTROL, ctl);
		idle(n);
		wr(gst_pkg::ADDR_CONTROL, 8'h00);
		rd(gst_pkg::ADDR_COUNT_LO, lo, hi);
	endtask
	// preset near rollover with the given interrupt control
	task automatic roll(input logic [7:0] ict, input logic exp_irq);
		wr(gst_pkg::ADDR_CONTROL, 8'h00);
		wr(gst_pkg::ADDR_COUNT_LO, 8'hfe);
		wr(gst_pkg::ADDR_COUNT_HI, 8'hff);
		wr(gst_pkg::ADDR_FLAGS, 8'h00);
		wr(gst_pkg::ADDR_ENABLES, 8'h01);
		wr(gst_pkg::ADDR_INTCTL, ict);
		wr(gst_pkg::ADDR_CONTROL, 8'h01);
		idle(20);
		chk_bit(irq_req, exp_irq, "irq");
		wr(gst_pkg::ADDR_CONTROL, 8'h00);
		rd(gst_pkg::ADDR_FLAGS, 8'h01, 8'h01);
		rd(gst_pkg::ADDR_COUNT_HI, 8'h00, 8'h00);
		wr(gst_pkg::ADDR_FLAGS, 8'h00);
		idle(3);
		chk_bit(irq_req, 1'b0, "irq after clear");
	endtask

	// read data checked in the cycle after the strobe, zero otherwise
	always @(posedge clock) begin
		rd_pend <= rd_en;
		if (rd_pend) begin
			chk_rd(rdata);
		end else if (rst_n && rdata !== 8'h00) begin
			fail("read data not idle");
		end
	end

	task automatic wrap_up();
		$display("errors %0d of %0d compares", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		idle(40000);
		fail("watchdog");
		wrap_up();
	end

	initial begin
		idle(5);
		rst_n <= 1'b1;
		idle(4);
		rd(gst_pkg::ADDR_CONTROL, 8'h00, 8'h00);
		rd(gst_pkg::ADDR_GATE_SRC, 8'h02, 8'h02);
		wr(gst_pkg::ADDR_GATE_SRC, 8'hff);
		rd(gst_pkg::ADDR_GATE_SRC, 8'h03, 8'h03);
		rd(gst_pkg::ADDR_COUNT_LO, 8'h00, 8'h00);
		wr(4'h7, 8'h5a);
		rd(4'h7, 8'h00, 8'h00);
		// random counter values written while stopped
		repeat (4) begin
			v = 16'($random(seed));
			wr(gst_pkg::ADDR_COUNT_LO, v[7:0]);
			wr(gst_pkg::ADDR_COUNT_HI, v[15:8]);
			rd(gst_pkg::ADDR_COUNT_LO, v[7:0], v[7:0]);
			rd(gst_pkg::ADDR_COUNT_HI, v[15:8], v[15:8]);
		end
		// six ticks at every prescale setting, then none at divide by 8 with run off
		for (int p = 0; p < 4; p++) begin
			meas({2'b00, p[1:0], 4'h1}, 24 * (1 << p) - 2, 8'h05, 8'h07);
		end
		meas(8'h30, 94, 8'h00, 8'h00);
		// gate source, polarity and level combinations
		for (int i = 0; i < 8; i++) begin
			wr(gst_pkg::ADDR_GATE_SRC, {6'h00, i[0], 1'b0});
			gate_lvl <= i[0] ? i[2] : ~i[2];
			cmp_lvl <= i[0] ? ~i[2] : i[2];
			meas({i[1], 7'h41}, 22, (i[2] == i[1]) ? 8'h05 : 8'h00, (i[2] == i[1]) ? 8'h07 : 8'h00);
		end
		gate_lvl <= 1'b0;
		meas(8'h81, 22, 8'h05, 8'h07);
		// external clock, rising edge every ten cycles
		ext_run <= 1'b1;
		meas(8'h03, 198, 8'h12, 8'h15);
		meas(8'h07, 198, 8'h12, 8'h15);
		meas(8'h02, 198, 8'h00, 8'h00);
		roll(8'hc0, 1'b1);
		roll(8'h40, 1'b0);
		roll(8'h80, 1'b0);
		// unsynchronised counter in sleep wakes the device
		wr(gst_pkg::ADDR_CONTROL, 8'h00);
		wr(gst_pkg::ADDR_COUNT_LO, 8'hf8);
		wr(gst_pkg::ADDR_COUNT_HI, 8'hff);
		wr(gst_pkg::ADDR_FLAGS, 8'h00);
		wr(gst_pkg::ADDR_ENABLES, 8'h01);
		wr(gst_pkg::ADDR_INTCTL, 8'h40);
		sleep_mode <= 1'b1;
		wr(gst_pkg::ADDR_CONTROL, 8'h07);
		idle(150);
		chk_bit(wake_req, 1'b1, "wake");
		chk_bit(irq_req, 1'b0, "irq in sleep");
		meas(8'h03, 198, 8'h00, 8'h00);
		sleep_mode <= 1'b0;
		// low-power oscillator only with internal oscillator
		int_osc <= 1'b1;
		wr(gst_pkg::ADDR_CONTROL, 8'h08);
		idle(2);
		chk_bit(lp_osc, 1'b1, "lp osc on");
		chk_bit(wake_req, 1'b0, "wake after sleep");
		int_osc <= 1'b0;
		idle(3);
		chk_bit(lp_osc, 1'b0, "lp osc ignored");
		wrap_up();
	end
endmodule
